// ### psbp_pkg.sv
// constants, types and burst helper for the pipelined burst sram port
package psbp_pkg;
   // ========================================
   // array shape and lane layout
   localparam int LANE_W = 9;    // eight data bits plus one parity bit
   localparam int BURST_LEN = 4;
   localparam int CNT_W = 2;
   localparam int PIPE_DEPTH = 2;   // edges from control to data phase
   localparam int ADDR_MAX = 19;
   localparam int LANE_MAX = 4;
   localparam int SYNC_LEN = 3;
   localparam int BUF_DEPTH = 2;

   // ========================================
   // values after reset, and the full buffer level
   localparam logic [1:0] CNT_RST = 2'h0;
   localparam logic [1:0] OCC_RST = 2'h0;
   localparam logic [1:0] OCC_FULL = 2'h2;
   localparam logic [2:0] SYNC_RST = 3'h0;
   localparam logic SLEEP_RST = 1'b0;
   localparam logic OE_N_RST = 1'b1;

   // ========================================
   // burst state and pipeline word
   typedef enum logic [1:0] {
      PSBP_IDLE = 2'b00,
      PSBP_RD = 2'b01,
      PSBP_WR = 2'b10
   } psbp_burst_t;

   typedef struct packed {
      logic vld;
      logic wr;
      logic [ADDR_MAX-1:0] addr;
      logic [LANE_MAX-1:0] lane_n;
   } psbp_op_t;

   localparam psbp_op_t OP_RST = '0;

   // low address bits of a burst word: linear adds, interleaved xors
   function automatic logic [1:0] psbp_burst_lo(input logic [1:0] start, input logic [1:0] cnt,
                                                input logic ilv);
      return ilv ? (start ^ cnt) : 2'(start + cnt);
   endfunction : psbp_burst_lo
endpackage : psbp_pkg

// ### psbp_port.sv
// pipelined burst sram port: pipeline, burst counter, array and read stream buffer
// Behaviour
// - array is 256Kx36 or 512Kx18 by variant
// - data phase two cycles after control
// - read and write follow back to back
// - clock hold freezes inputs and the control pipeline; sync flops and read stream buffer keep running
// - any select inactive at load: no operation
// - pending data phases still complete after deselect
// - bus released two cycles after deselect/write
// - counter gives four words per address
// - order select picks linear or interleaved
// - load low loads address, high advances
// - inactive output enable forces outputs off
// - address captured only on selected running load
// - deselect at load ends running burst
// - advance moves counter, ignores address pins
// - read_not_write marks load as read/write
// - order select high interleaved, held static
// - per-lane write strobes, ignored on reads
// - deselect: a_n high, b low, c_n high
// - sleep gates clock, keeps stored data
`timescale 1ns/1ns
module psbp_port #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 36,
   parameter int LANES = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic advance_or_load,
   input wire logic read_not_write,
   input wire logic select_a_n,
   input wire logic select_b,
   input wire logic select_c_n,
   input wire logic clk_hold_n,
   input wire logic [LANES-1:0] lane_write_n,
   input wire logic burst_order_sel_n,
   input wire logic out_en_n,
   input wire logic sleep_req,
   input wire logic [DATA_W-1:0] data_io_i,
   output logic [DATA_W-1:0] data_io_o,
   output logic data_io_oe,
   output logic rdq_valid,
   input wire logic rdq_ready,
   output logic [DATA_W-1:0] rdq_data,
   output logic rdq_in_ready
);
   localparam int AM = psbp_pkg::ADDR_MAX;
   localparam int LM = psbp_pkg::LANE_MAX;
   localparam int LW = psbp_pkg::LANE_W;

   // ========================================
   // variant check
   // only the two documented shapes are served
   if (!((ADDR_W == 18 && DATA_W == 36 && LANES == 4) ||
         (ADDR_W == 19 && DATA_W == 18 && LANES == 2))) begin : g_bad_shape
      $error("psbp_port: unsupported array shape");
   end

   // ========================================
   // asynchronous pins: three flops, change counts when 2nd and 3rd agree
   logic [2:0] slp_sync_q;
   logic [2:0] oe_sync_q;
   logic slp_q;
   logic oe_n_q;

   function automatic logic filt(input logic [2:0] s, input logic cur);
      return (s[2] == s[1]) ? s[2] : cur;
   endfunction : filt

   // sync chains, first flop feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         slp_sync_q <= psbp_pkg::SYNC_RST;
         oe_sync_q <= ~psbp_pkg::SYNC_RST;
         slp_q <= psbp_pkg::SLEEP_RST;
         oe_n_q <= psbp_pkg::OE_N_RST;
      end else begin
         slp_sync_q <= {slp_sync_q[1:0], sleep_req};
         oe_sync_q <= {oe_sync_q[1:0], out_en_n};
         slp_q <= filt(slp_sync_q, slp_q);
         oe_n_q <= filt(oe_sync_q, oe_n_q);
      end
   end

   // ========================================
   // input decode
   psbp_pkg::psbp_burst_t bst_q;
   psbp_pkg::psbp_burst_t bst_d;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [AM-1:0] base_q;
   logic [AM-1:0] base_d;
   psbp_pkg::psbp_op_t s1_q;
   psbp_pkg::psbp_op_t s2_q;
   psbp_pkg::psbp_op_t s1_d;
   psbp_pkg::psbp_op_t ld_op;
   psbp_pkg::psbp_op_t adv_op;

   // run only when hold is low and the chip is awake
   wire run = !clk_hold_n && !slp_q;
   wire sel_ok = !select_a_n && select_b && !select_c_n;
   wire load = run && !advance_or_load;
   wire new_op = load && sel_ok;
   wire desel = load && !sel_ok;
   wire adv = run && advance_or_load && (bst_q != psbp_pkg::PSBP_IDLE);
   wire ilv = burst_order_sel_n;
   wire oe_act = !oe_n_q;

   // next burst word address from the latched start
   wire [1:0] cnt_nx = 2'(cnt_q + 2'h1);
   wire [1:0] lo_nx = psbp_pkg::psbp_burst_lo(base_q[1:0], cnt_nx, ilv);

   // operation words for load and advance
   assign ld_op = '{vld: 1'b1, wr: !read_not_write, addr: AM'(addr_in),
                    lane_n: LM'(lane_write_n)};
   assign adv_op = '{vld: 1'b1, wr: (bst_q == psbp_pkg::PSBP_WR),
                     addr: {base_q[AM-1:2], lo_nx}, lane_n: LM'(lane_write_n)};
   assign s1_d = new_op ? ld_op : (adv ? adv_op : psbp_pkg::OP_RST);

   // burst tracking: load starts, deselect ends, advance counts
   assign bst_d = new_op ? (read_not_write ? psbp_pkg::PSBP_RD : psbp_pkg::PSBP_WR)
                : (desel ? psbp_pkg::PSBP_IDLE : bst_q);
   assign cnt_d = new_op ? psbp_pkg::CNT_RST : (adv ? cnt_nx : cnt_q);
   assign base_d = new_op ? AM'(addr_in) : base_q;

   // ========================================
   // control pipeline, frozen while held or asleep
   always_ff @(posedge clk) begin
      if (srst) begin
         bst_q <= psbp_pkg::PSBP_IDLE;
         cnt_q <= psbp_pkg::CNT_RST;
         base_q <= '0;
         s1_q <= psbp_pkg::OP_RST;
         s2_q <= psbp_pkg::OP_RST;
      end else if (run) begin
         bst_q <= bst_d;
         cnt_q <= cnt_d;
         base_q <= base_d;
         s1_q <= s1_d;
         s2_q <= s1_q;
      end
   end

   // ========================================
   // array and data phase
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] dout_q;
   logic rd_phase_q;
   logic rdw_vld_q;
   logic oe_q;

   wire [ADDR_W-1:0] a2 = s2_q.addr[ADDR_W-1:0];
   wire wr_now = run && s2_q.vld && s2_q.wr;
   wire rd_now = run && s2_q.vld && !s2_q.wr;
   wire rd_phase_d = run ? rd_now : rd_phase_q;

   // lane writes, strobes only used on write words; no reset keeps data
   always_ff @(posedge clk) begin
      if (wr_now) begin
         for (int i = 0; i < LANES; i++) begin
            if (!s2_q.lane_n[i]) begin
               mem[a2][i*LW +: LW] <= data_io_i[i*LW +: LW];
            end
         end
      end
   end

   // read register and bus drive
   always_ff @(posedge clk) begin
      if (srst) begin
         dout_q <= '0;
         rd_phase_q <= 1'b0;
         rdw_vld_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         if (rd_now) begin
            dout_q <= mem[a2];
         end
         rd_phase_q <= rd_phase_d;
         rdw_vld_q <= rd_now;
         oe_q <= rd_phase_d && oe_act;
      end
   end

   assign data_io_o = dout_q;
   assign data_io_oe = oe_q;

   // ========================================
   // two-entry read stream buffer
   logic [1:0] occ_q;
   logic [1:0] occ_d;
   logic [DATA_W-1:0] head_q;
   logic [DATA_W-1:0] tail_q;
   logic vld_q;
   logic rdy_q;

   // push from read path, pop by the receiver
   wire push = rdw_vld_q && rdy_q;
   wire pop = vld_q && rdq_ready;
   wire tail_ld = push && !pop && (occ_q == 2'h1);

   // occupancy update
   always_comb begin
      occ_d = occ_q;
      if (push && !pop) begin
         occ_d = 2'(occ_q + 2'h1);
      end else if (pop && !push) begin
         occ_d = 2'(occ_q - 2'h1);
      end
   end

   // head, tail and flags
   always_ff @(posedge clk) begin
      if (srst) begin
         occ_q <= psbp_pkg::OCC_RST;
         head_q <= '0;
         tail_q <= '0;
         vld_q <= 1'b0;
         rdy_q <= 1'b1;
      end else begin
         occ_q <= occ_d;
         vld_q <= (occ_d != psbp_pkg::OCC_RST);
         rdy_q <= (occ_d != psbp_pkg::OCC_FULL);
         if (tail_ld) begin
            tail_q <= dout_q;
         end
         if (pop) begin
            head_q <= (occ_q == psbp_pkg::OCC_FULL) ? tail_q : dout_q;
         end else if (push && occ_q == psbp_pkg::OCC_RST) begin
            head_q <= dout_q;
         end
      end
   end

   assign rdq_valid = vld_q;
   assign rdq_data = head_q;
   assign rdq_in_ready = rdy_q;

   // ========================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_read_two_cycles: assert property (
      (new_op && read_not_write) ##1 run ##1 run |=> rd_phase_q && $past(s2_q.addr) == $past(base_q, 2))
      else $error("read data phase not two cycles after load");

   a_write_release: assert property (
      (new_op && !read_not_write) ##1 run ##1 run |=> !data_io_oe)
      else $error("bus driven in write data phase");

   a_hold_freeze: assert property (
      !run |=> $stable(s1_q) && $stable(s2_q) && $stable(bst_q) && $stable(cnt_q))
      else $error("registers moved while held");

   a_desel_no_op: assert property (
      desel |=> !s1_q.vld && bst_q == psbp_pkg::PSBP_IDLE)
      else $error("deselect started an operation");

   a_pending_done: assert property (
      (run && s1_q.vld && !s1_q.wr && desel) ##1 run |=> rd_phase_q)
      else $error("pending read dropped on deselect");

   a_turn_around: assert property (
      (run && s2_q.vld && s2_q.wr && s1_q.vld && !s1_q.wr) ##1 run |=> rd_phase_q)
      else $error("read after write lost a cycle");

   a_linear_step: assert property (
      (adv && !burst_order_sel_n && s1_q.vld) |=> s1_q.addr[1:0] == 2'($past(s1_q.addr[1:0]) + 2'h1))
      else $error("linear burst step wrong");

   a_ilv_step: assert property (
      (adv && burst_order_sel_n) |=> (s1_q.addr[1:0] ^ base_q[1:0]) == cnt_q)
      else $error("interleaved burst address wrong");

   a_addr_ignored: assert property (
      adv |=> s1_q.addr[AM-1:2] == $past(base_q[AM-1:2]) && s1_q.vld)
      else $error("advance used address pins");

   a_oe_gate: assert property (
      !oe_act ##1 !oe_act |-> !data_io_oe)
      else $error("bus driven with output enable off");

   a_sleep_freeze: assert property (
      slp_q |=> $stable(s2_q) && $stable(dout_q) && $stable(bst_q))
      else $error("pipeline moved while asleep");

   a_desel_release: assert property (
      desel ##1 run ##1 run |=> !data_io_oe)
      else $error("bus still driven two cycles after deselect");

   a_adv_idle: assert property (
      (run && advance_or_load && bst_q == psbp_pkg::PSBP_IDLE) |=> !s1_q.vld)
      else $error("advance without a burst started an operation");

   a_load_capture: assert property (
      new_op |=> s1_q.addr[ADDR_W-1:0] == $past(addr_in) && s1_q.wr == !$past(read_not_write))
      else $error("load did not capture address and direction");
endmodule : psbp_port

// ### psbp_host.sv
// host model: puts write words on the data pins in their data phase
`timescale 1ns/1ns
module psbp_host (
   input wire logic clk,
   input wire logic clk_hold_n,
   input wire logic wr_word,
   input wire logic [35:0] wr_data,
   output logic [35:0] data_io_i
);
   logic [36:0] st1_q = '0;
   logic [36:0] st2_q = '0;
   logic [35:0] junk_q = 36'h5_5555_5555;
   // ========================================
   // write word waits two running edges; held edges do not count
   always @(posedge clk) begin
      junk_q <= ~junk_q;
      if (!clk_hold_n) begin
         st1_q <= {wr_word, wr_data};
         st2_q <= st1_q;
      end
   end
   // outside a write phase the bus shows a changing pattern
   assign data_io_i = st2_q[36] ? st2_q[35:0] : junk_q;
endmodule : psbp_host

// ### test_pipelined_burst_sram_port.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ns
module test_pipelined_burst_sram_port;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [17:0] addr_in = '0;
   logic advance_or_load = 1'b0;
   logic read_not_write = 1'b1;
   logic select_a_n = 1'b0;
   logic select_b = 1'b0;
   logic select_c_n = 1'b0;
   logic clk_hold_n = 1'b0;
   logic [3:0] lane_write_n = '1;
   logic burst_order_sel_n = 1'b0;
   logic out_en_n = 1'b0;
   logic sleep_req = 1'b0;
   logic rdq_ready = 1'b1;
   logic wr_word = 1'b0;
   logic [35:0] wr_data = '0;
   logic [35:0] salt = '0;
   logic [35:0] data_io_i, data_io_o, rdq_data;
   logic data_io_oe, rdq_valid, rdq_in_ready;
   logic [35:0] mem [logic [17:0]];
   logic [36:0] expq [$];
   logic [35:0] rdq_exp [$];
   logic [17:0] base_q = '0;
   logic [1:0] cnt_q = '0;
   int kind_q = 0;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;

   // ========================================
   // design, host model, clock and watchdog
   psbp_port i_psbp_port (.clk(clk), .srst(srst), .addr_in(addr_in), .advance_or_load(advance_or_load),
      .read_not_write(read_not_write), .select_a_n(select_a_n), .select_b(select_b), .select_c_n(select_c_n),
      .clk_hold_n(clk_hold_n), .lane_write_n(lane_write_n), .burst_order_sel_n(burst_order_sel_n),
      .out_en_n(out_en_n), .sleep_req(sleep_req), .data_io_i(data_io_i), .data_io_o(data_io_o),
      .data_io_oe(data_io_oe), .rdq_valid(rdq_valid), .rdq_ready(rdq_ready), .rdq_data(rdq_data),
      .rdq_in_ready(rdq_in_ready));
   psbp_host i_psbp_host (.clk(clk), .clk_hold_n(clk_hold_n), .wr_word(wr_word), .wr_data(wr_data),
      .data_io_i(data_io_i));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         $display("BAD %0t watchdog expired", $time);
         report_and_stop();
      end
   end

   // ========================================
   // shared helpers
   task automatic check(input logic ok, input string what);
      check_count++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : check

   // one running edge; ds 1 drops select_b, ds 2 raises select_c_n, ds 3 raises select_a_n
   task automatic step(input logic adv, input logic rnw, input logic [17:0] a, input logic [3:0] ln, input int ds);
      logic [17:0] wa;
      logic [35:0] m;
      logic [36:0] e;
      e = '0;
      clk_hold_n = 1'b0;
      advance_or_load = adv;
      read_not_write = rnw;
      addr_in = a;
      lane_write_n = ln;
      select_b = (ds != 1);
      select_c_n = (ds == 2);
      select_a_n = (ds == 3);
      if (!adv) begin
         kind_q = (ds != 0) ? 0 : (rnw ? 1 : 2);
         base_q = a;
         cnt_q = 2'h0;
      end else begin
         cnt_q = cnt_q + 2'h1;
      end
      wa = {base_q[17:2], burst_order_sel_n ? base_q[1:0] ^ cnt_q : base_q[1:0] + cnt_q};
      for (int i = 0; i < 4; i++) m[i*9 +: 9] = {9{~ln[i]}};
      wr_word = (kind_q == 2);
      wr_data = {wa, ~wa} ^ salt;
      if (kind_q == 2) mem[wa] = (mem[wa] & ~m) | (wr_data & m);
      if (kind_q == 1 && !out_en_n) e = {1'b1, mem[wa]};
      if (e[36]) rdq_exp.push_back(e[35:0]);
      expq.push_back(e);
      @(negedge clk);
      if (expq.size() == 3) begin
         e = expq.pop_front();
         check(data_io_oe === e[36], "bus drive");
         if (e[36]) check(data_io_o === e[35:0], "read word");
      end
   endtask : step

   task automatic idle(input int n);
      repeat (n) step(1'b0, 1'b1, 18'h0_0000, 4'hf, 1);
   endtask : idle

   // a suspended edge with a write load on the pins
   task automatic hold_edge();
      logic o;
      o = data_io_oe;
      clk_hold_n = 1'b1;
      advance_or_load = 1'b0;
      read_not_write = 1'b0;
      select_b = 1'b1;
      addr_in = 18'h0_0122;
      @(negedge clk);
      check(data_io_oe === o, "held edge");
   endtask : hold_edge

   // ========================================
   // scenarios
   task automatic t_order(input logic ilv);
      burst_order_sel_n = ilv;
      salt = {36{ilv}};
      for (int i = 0; i < 4; i++) step(1'b0, 1'b0, 18'h0_0120 + 18'(i), 4'h0, 0);
      step(1'b0, 1'b1, 18'h0_0121, 4'hf, 0);
      repeat (3) step(1'b1, 1'b1, 18'h3_ffff, 4'h0, 0);
      step(1'b0, 1'b1, 18'h0_0120, 4'hf, 2);
      step(1'b1, 1'b1, 18'h0_0120, 4'hf, 0);
      step(1'b0, 1'b1, 18'h0_0122, 4'hf, 0);
      step(1'b0, 1'b1, 18'h0_0122, 4'hf, 3);
      step(1'b1, 1'b1, 18'h0_0122, 4'hf, 0);
      idle(2);
   endtask : t_order

   task automatic t_lanes();
      salt = 36'h0_0000_0000;
      step(1'b0, 1'b1, 18'h0_0122, 4'hf, 0);
      step(1'b0, 1'b0, 18'h0_0122, 4'ha, 0);
      hold_edge();
      step(1'b0, 1'b1, 18'h0_0122, 4'h0, 0);
      idle(2);
   endtask : t_lanes

   // sleep with a write load on the pins: the word must not land, stored data stays
   task automatic t_sleep();
      idle(2);
      sleep_req = 1'b1;
      repeat (4) @(negedge clk);
      advance_or_load = 1'b0;
      read_not_write = 1'b0;
      select_b = 1'b1;
      addr_in = 18'h0_0121;
      lane_write_n = 4'h0;
      wr_word = 1'b1;
      wr_data = 36'h0_0000_0000;
      repeat (3) @(negedge clk);
      check(data_io_oe === 1'b0 && rdq_valid === 1'b0, "activity while asleep");
      select_b = 1'b0;
      wr_word = 1'b0;
      sleep_req = 1'b0;
      repeat (5) @(negedge clk);
      expq.delete();
      step(1'b0, 1'b1, 18'h0_0121, 4'hf, 0);
      idle(2);
   endtask : t_sleep

   task automatic t_oe();
      out_en_n = 1'b1;
      idle(5);
      step(1'b0, 1'b1, 18'h0_0120, 4'hf, 0);
      idle(2);
      out_en_n = 1'b0;
      idle(5);
   endtask : t_oe

   task automatic t_stream();
      burst_order_sel_n = 1'b0;
      rdq_exp.delete();
      rdq_ready = 1'b0;
      step(1'b0, 1'b1, 18'h0_0120, 4'hf, 0);
      repeat (3) step(1'b1, 1'b1, 18'h0_0000, 4'hf, 0);
      idle(4);
      check(rdq_in_ready === 1'b0, "buffer not full");
      rdq_ready = 1'b1;
      for (int k = 0; k < 2; k++) begin
         check(rdq_valid === 1'b1 && rdq_data === rdq_exp[k], "stream word");
         @(negedge clk);
      end
      check(rdq_valid === 1'b0, "buffer not empty");
   endtask : t_stream

   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // ========================================
   // main sequence
   initial begin
      repeat (5) @(negedge clk);
      check(data_io_oe === 1'b0 && rdq_valid === 1'b0 && rdq_in_ready === 1'b1, "reset outputs");
      srst = 1'b0;
      t_order(1'b0);
      t_order(1'b1);
      t_lanes();
      t_sleep();
      t_oe();
      t_stream();
      report_and_stop();
   end
endmodule : test_pipelined_burst_sram_port
